// ===== logic/ufc_channel.sv
// Purpose: one channel's fifos, fifo control word and ready outputs
// Assumes: single clock, writes arrive as one-cycle strobes
// Notes: transmit side is drained by an external shifter strobe
`timescale 1ns/100ps
module ufc_channel #(
	parameter int DEPTH = ufc_pkg::FIFO_DEPTH
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// register strobes
	input wire logic ctl_wr,
	input wire logic [7:0] ctl_data,
	input wire logic tx_wr,
	input wire logic [7:0] tx_data,
	input wire logic rx_rd,
	input wire logic sel_wr,
	input wire logic sel_data,
	// serial side
	input wire logic tx_take,
	input wire logic rx_put,
	input wire logic [7:0] rx_char,
	input wire logic rx_timeout,
	// state
	output logic [7:0] fifo_control,
	output logic [7:0] rx_head,
	output logic [4:0] tx_count,
	output logic [4:0] rx_count,
	output logic multifunction_pin_select,
	output logic rx_int,
	output logic transmit_ready_n,
	output logic receive_ready_n,
	output logic [7:0] tx_head
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [4:0] FULL = 5'(DEPTH);

	// ==========================================
	// trigger decode
	function automatic logic [4:0] trig_level(input logic [1:0] code);
		case (code)
			2'h0: trig_level = ufc_pkg::TRIG_L0;
			2'h1: trig_level = ufc_pkg::TRIG_L1;
			2'h2: trig_level = ufc_pkg::TRIG_L2;
			default: trig_level = ufc_pkg::TRIG_L3;
		endcase
	endfunction : trig_level

	logic [7:0] tx_mem [DEPTH];
	logic [7:0] rx_mem [DEPTH];
	logic [AW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
	logic rx_latched;

	wire fifo_en = fifo_control[ufc_pkg::FC_ENABLE];
	wire dma1 = fifo_en & fifo_control[ufc_pkg::FC_DMA_MODE];
	// holding-register operation when fifos are off: one location only
	wire [4:0] cap = fifo_en ? FULL : 5'h01;
	wire [4:0] trig = trig_level(fifo_control[7:6]);
	wire prog = ctl_wr & ctl_data[ufc_pkg::FC_ENABLE];
	// enable toggling or explicit flush empties a side
	wire en_change = ctl_wr & (ctl_data[ufc_pkg::FC_ENABLE] != fifo_en);
	wire tx_flush = (prog & ctl_data[ufc_pkg::FC_TX_FLUSH]) | en_change;
	wire rx_flush = (prog & ctl_data[ufc_pkg::FC_RX_FLUSH]) | en_change;
	wire tx_push = tx_wr & (tx_count < cap) & ~tx_flush;
	wire tx_pop = tx_take & (tx_count != 5'h00) & ~tx_flush;
	// reception continues past the trigger until every slot is taken
	wire rx_push = rx_put & (rx_count < cap) & ~rx_flush;
	wire rx_pop = rx_rd & (rx_count != 5'h00) & ~rx_flush;
	wire [4:0] next_tx_count = tx_flush ? 5'h00 : tx_count + 5'(tx_push) - 5'(tx_pop);
	wire [4:0] next_rx_count = rx_flush ? 5'h00 : rx_count + 5'(rx_push) - 5'(rx_pop);
	// mode 1 receive ready sets on trigger or time-out, holds until empty
	wire rx_set = (next_rx_count >= trig) | rx_timeout;
	wire next_rx_latched = (next_rx_count != 5'h00) & (rx_latched | rx_set);
	wire next_txr_n = dma1 ? (next_tx_count == FULL) : (next_tx_count != 5'h00);
	wire next_rxr_n = dma1 ? ~next_rx_latched : (next_rx_count == 5'h00);

	// ==========================================
	// control word: bits 5-4 held zero, flush bits self clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fifo_control <= ufc_pkg::FC_RESET;
		end else if (prog) begin
			fifo_control <= ctl_data & ufc_pkg::FC_KEEP_MASK;
		end else if (ctl_wr) begin
			fifo_control <= {fifo_control[7:1], 1'b0};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_wp <= '0;
			tx_rp <= '0;
			rx_wp <= '0;
			rx_rp <= '0;
			tx_count <= 5'h00;
			rx_count <= 5'h00;
			rx_latched <= 1'b0;
			transmit_ready_n <= 1'b0;
			receive_ready_n <= 1'b1;
			rx_int <= 1'b0;
			multifunction_pin_select <= 1'b0;
		end else begin
			tx_wp <= tx_flush ? '0 : tx_wp + AW'(tx_push);
			tx_rp <= tx_flush ? '0 : tx_rp + AW'(tx_pop);
			rx_wp <= rx_flush ? '0 : rx_wp + AW'(rx_push);
			rx_rp <= rx_flush ? '0 : rx_rp + AW'(rx_pop);
			tx_count <= next_tx_count;
			rx_count <= next_rx_count;
			rx_latched <= next_rx_latched;
			transmit_ready_n <= next_txr_n;
			receive_ready_n <= next_rxr_n;
			// interrupt at the trigger, withdrawn below it; with fifos off, while a character is held
			rx_int <= fifo_en ? (next_rx_count >= trig) : (next_rx_count != 5'h00);
			if (sel_wr) begin
				multifunction_pin_select <= sel_data;
			end
		end
	end

	always_ff @(posedge pclk) begin
		if (tx_push) begin
			tx_mem[tx_wp] <= tx_data;
		end
		if (rx_push) begin
			rx_mem[rx_wp] <= rx_char;
		end
	end

	assign rx_head = rx_mem[rx_rp];
	assign tx_head = tx_mem[tx_rp];

	// ==========================================
	// checks
	reg_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
		fifo_control[5:4] == 2'h0 && fifo_control[2:1] == 2'h0)
		else $error("reserved or flush bits stuck");
	gated_prog_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctl_wr && !ctl_data[0] |=> fifo_control[7:3] == $past(fifo_control[7:3]))
		else $error("control bits changed without enable");
	tx_flush_a: assert property (@(posedge pclk) disable iff (!presetn)
		prog && ctl_data[2] |=> tx_count == 5'h00)
		else $error("transmit flush left data");
	rx_flush_a: assert property (@(posedge pclk) disable iff (!presetn)
		prog && ctl_data[1] |=> rx_count == 5'h00)
		else $error("receive flush left data");
	tx_mode0_a: assert property (@(posedge pclk) disable iff (!presetn)
		!dma1 && $past(!dma1) |-> transmit_ready_n == (tx_count != 5'h00))
		else $error("mode 0 transmit ready wrong");
	tx_mode1_a: assert property (@(posedge pclk) disable iff (!presetn)
		dma1 && $past(dma1) |-> transmit_ready_n == (tx_count == FULL))
		else $error("mode 1 transmit ready wrong");
	rx_mode0_a: assert property (@(posedge pclk) disable iff (!presetn)
		!dma1 && $past(!dma1) |-> receive_ready_n == (rx_count == 5'h00))
		else $error("mode 0 receive ready wrong");
	// mode must already have been 1 when the low level was launched, else it is a mode 0 low
	sequence rx_active_s;
		$past(dma1) && dma1 && !receive_ready_n && rx_count != 5'h00
		##1 dma1 && rx_count != 5'h00;
	endsequence
	rx_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		rx_active_s |-> !receive_ready_n)
		else $error("mode 1 receive ready released early");
	rx_trig_a: assert property (@(posedge pclk) disable iff (!presetn)
		fifo_en && $past(fifo_en) && $past(fifo_control[7:6]) == fifo_control[7:6]
		|-> rx_int == (rx_count >= trig))
		else $error("receive interrupt does not follow trigger");
	rx_fill_a: assert property (@(posedge pclk) disable iff (!presetn)
		fifo_en && rx_put && !ctl_wr && !rx_rd && rx_count < FULL
		|=> rx_count == $past(rx_count) + 5'h01)
		else $error("reception stopped before full");
endmodule : ufc_channel

// ===== shared/ufc_pkg.sv
// Purpose: constants for the fifo control and dma ready block
// Assumes: apb with 32-bit data, one word per register
// Notes: register offsets beyond the fifo control word are local choices
package ufc_pkg;
	// ==========================================
	// register map, byte addresses within a channel
	localparam logic [7:0] OFF_FIFO_CONTROL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_TX_DATA = 8'h08;
	localparam logic [7:0] OFF_RX_DATA = 8'h0C;
	localparam logic [7:0] OFF_PIN_SELECT = 8'h10;
	localparam logic [7:0] OFF_CH_STRIDE = 8'h20;
	// ==========================================
	// fifo control fields
	localparam int FC_ENABLE = 0;
	localparam int FC_RX_FLUSH = 1;
	localparam int FC_TX_FLUSH = 2;
	localparam int FC_DMA_MODE = 3;
	localparam int FC_TRIG_LO = 6;
	localparam logic [7:0] FC_RESET = 8'h00;
	localparam logic [7:0] FC_KEEP_MASK = 8'hC9;
	// ==========================================
	// status fields
	localparam int ST_TX_READY_N = 0;
	localparam int ST_RX_READY_N = 1;
	localparam int ST_RX_INT = 2;
	localparam int ST_FIFO_ON_LO = 6;
	// ==========================================
	// trigger levels
	localparam logic [4:0] TRIG_L0 = 5'h01;
	localparam logic [4:0] TRIG_L1 = 5'h04;
	localparam logic [4:0] TRIG_L2 = 5'h08;
	localparam logic [4:0] TRIG_L3 = 5'h0E;
	localparam int FIFO_DEPTH = 16;
endpackage : ufc_pkg

// ===== logic/ufc_top.sv
// Purpose: apb slave for two channels of fifo control and dma ready logic
// Assumes: serial shifters outside; all serial-side inputs are synchronous
// Notes: zero wait-state apb, pready low in reset and high from the first clock after it
// Notes on behaviour
// - receive interrupt condition raised when receive count equals trigger level
// - receive fifo keeps filling past the trigger until full
// - trigger code 00,01,10,11 gives 1,4,8,14 characters
// - control bits five and four always read zero
// - control bit three selects dma mode, mode 0 after reset
// - fifos off or mode 0: transmit ready low when transmit side empty; the transmit_ready_n pins are held high during reset
// - mode 0: transmit ready goes high on first character written
// - fifos off or mode 0: receive ready low while any character held
// - mode 0: receive ready returns high when receiver empty
// - mode 1: transmit ready high only when transmit fifo full
// - mode 1: receive ready low on trigger level or receive time-out
// - mode 1: receive ready held low until receive fifo empty
// - control bit two flushes transmit fifo and self clears
// - control bit one flushes receive fifo and self clears
// - control bit zero enables both fifos, zero after reset
// - other control bits change only on writes with bit zero set
// - status bits seven and six read ones while fifos enabled
// - receive interrupt withdrawn when fill drops below trigger
`timescale 1ns/100ps
module ufc_top (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial side, channel a then b
	input wire logic [1:0] tx_take,
	input wire logic [1:0] rx_put,
	input wire logic [15:0] rx_char,
	input wire logic [1:0] rx_timeout,
	// ready and data outputs
	output logic [1:0] transmit_ready_n,
	output logic [1:0] multifunction_pin,
	output logic [15:0] tx_char
);
	// ==========================================
	// decode
	wire access_ph = psel & penable;
	wire ch = paddr[5];
	wire [7:0] off = paddr & 8'h1F;
	wire hit_ctl = off == ufc_pkg::OFF_FIFO_CONTROL;
	wire hit_st = off == ufc_pkg::OFF_STATUS;
	wire hit_tx = off == ufc_pkg::OFF_TX_DATA;
	wire hit_rx = off == ufc_pkg::OFF_RX_DATA;
	wire hit_sel = off == ufc_pkg::OFF_PIN_SELECT;
	wire mapped = (paddr[7:6] == 2'h0) & (hit_ctl | hit_st | hit_tx | hit_rx | hit_sel);
	wire wr = access_ph & pwrite & mapped;
	wire rd = access_ph & ~pwrite & mapped;

	logic [7:0] fc [2];
	logic [7:0] rxh [2];
	logic [7:0] txh [2];
	logic [4:0] txc [2];
	logic [4:0] rxc [2];
	logic [1:0] pin_sel, rxint, txr, rxr;
	logic [31:0] rd_word [2];

	// independent channels
	for (genvar i = 0; i < 2; i++) begin : g_ch
		wire me = ch == 1'(i);
		ufc_channel u_ch (
			.pclk(pclk),
			.presetn(presetn),
			.ctl_wr(wr & me & hit_ctl),
			.ctl_data(pwdata[7:0]),
			.tx_wr(wr & me & hit_tx),
			.tx_data(pwdata[7:0]),
			.rx_rd(rd & me & hit_rx),
			.sel_wr(wr & me & hit_sel),
			.sel_data(pwdata[0]),
			.tx_take(tx_take[i]),
			.rx_put(rx_put[i]),
			.rx_char(rx_char[8*i +: 8]),
			.rx_timeout(rx_timeout[i]),
			.fifo_control(fc[i]),
			.rx_head(rxh[i]),
			.tx_count(txc[i]),
			.rx_count(rxc[i]),
			.multifunction_pin_select(pin_sel[i]),
			.rx_int(rxint[i]),
			.transmit_ready_n(txr[i]),
			.receive_ready_n(rxr[i]),
			.tx_head(txh[i])
		);
		// fifo-enabled flag shows in status bits seven and six
		assign rd_word[i] = hit_ctl ? {24'h0, fc[i]} :
			hit_st ? {16'h0, 3'h0, rxc[i], {2{fc[i][0]}}, 3'h0, rxint[i], rxr[i], txr[i]} :
			hit_rx ? {24'h0, rxh[i]} :
			hit_sel ? {31'h0, pin_sel[i]} :
			{27'h0, txc[i]};
	end

	// ==========================================
	// registered outputs; pin shows receive ready only when selected
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			transmit_ready_n <= 2'h3;
			multifunction_pin <= 2'h3;
			tx_char <= 16'h0;
		end else begin
			prdata <= rd_word[ch];
			pready <= 1'b1;
			pslverr <= psel & ~mapped;
			transmit_ready_n <= txr;
			multifunction_pin <= rxr | ~pin_sel;
			tx_char <= {txh[1], txh[0]};
		end
	end
endmodule : ufc_top

// ===== test/ufc_serial_model.sv
// Purpose: serial-side partner, stands in for the shifters and time-out detector
// Assumes: one clock, strobes are one cycle wide
// Notes: receive data lines show the inverse of the last char once released
`timescale 1ns/100ps
module ufc_serial_model (
	// clock
	input wire logic pclk,
	// serial side, channel a then b
	output logic [1:0] tx_take,
	output logic [1:0] rx_put,
	output logic [15:0] rx_char,
	output logic [1:0] rx_timeout
);
	initial begin
		tx_take = 2'b00;
		rx_put = 2'b00;
		rx_char = 16'h0000;
		rx_timeout = 2'b00;
	end
	// ==========================================
	// strobes, each followed by an idle cycle
	task automatic push(input int ch, input logic [7:0] c);
		rx_put[ch] <= 1'b1;
		rx_char[8*ch+:8] <= c;
		@(posedge pclk);
		rx_put[ch] <= 1'b0;
		rx_char[8*ch+:8] <= ~c;
		@(posedge pclk);
	endtask : push
	task automatic take(input int ch);
		tx_take[ch] <= 1'b1;
		@(posedge pclk);
		tx_take[ch] <= 1'b0;
		@(posedge pclk);
	endtask : take
	task automatic tmo(input int ch);
		rx_timeout[ch] <= 1'b1;
		@(posedge pclk);
		rx_timeout[ch] <= 1'b0;
		@(posedge pclk);
	endtask : tmo
endmodule : ufc_serial_model

// ===== test/tb.sv
// Purpose: self-checking bench for the fifo control and dma ready block
// Assumes: zero wait-state apb, outputs settle two clocks after their cause
// Notes: ready pins are sampled three clocks after each action
`timescale 1ns/100ps
module tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err_seen;
	logic [1:0] tx_take, rx_put, rx_timeout, transmit_ready_n, multifunction_pin;
	logic [15:0] rx_char, tx_char;
	int error_cnt = 0;
	int n_checks = 0;
	int cycles = 0;
	int lv[4] = '{1, 4, 8, 14};
	localparam logic [7:0] FC = ufc_pkg::OFF_FIFO_CONTROL;
	localparam logic [7:0] ST = ufc_pkg::OFF_STATUS;
	localparam logic [7:0] TX = ufc_pkg::OFF_TX_DATA;
	localparam logic [7:0] RX = ufc_pkg::OFF_RX_DATA;
	always #5 pclk = ~pclk;
	ufc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_take(tx_take), .rx_put(rx_put), .rx_char(rx_char),
		.rx_timeout(rx_timeout), .transmit_ready_n(transmit_ready_n),
		.multifunction_pin(multifunction_pin), .tx_char(tx_char));
	ufc_serial_model i_ser (.pclk(pclk), .tx_take(tx_take), .rx_put(rx_put),
		.rx_char(rx_char), .rx_timeout(rx_timeout));
	// ==========================================
	// reporting
	task automatic conclude();
		if (error_cnt == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			error_cnt++;
			conclude();
		end
	end
	// ==========================================
	// apb master, ends one idle edge after release
	task automatic apb(input logic w, input int ch, input logic [7:0] off, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= off + (ch == 1 ? ufc_pkg::OFF_CH_STRIDE : 8'h00);
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge pclk);
		end
		if (n == 50) error_cnt++;
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input int ch, input logic [7:0] off, input logic [31:0] d);
		apb(1'b1, ch, off, d);
	endtask : wr
	task automatic rdr(input int ch, input logic [7:0] off);
		apb(1'b0, ch, off, 32'h00000000);
	endtask : rdr
	task automatic idle();
		repeat (3) @(posedge pclk);
	endtask : idle
	// ==========================================
	// tests
	initial begin
		repeat (3) @(posedge pclk);
		check("pready_reset", pready, 1'b0);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rdr(0, FC); check("fc_reset", rd, 32'h00000000);
		check("txr_reset", transmit_ready_n, 2'b00);
		wr(0, FC, 32'h000000FF); rdr(0, FC); check("fc_bits", rd, 32'h000000C9);
		rdr(0, ST); check("fifo_on_st", rd[7:6], 2'b11);
		rdr(1, FC); check("fc_other_ch", rd, 32'h00000000);
		wr(0, FC, 32'h00000008); rdr(0, FC); check("fc_keep", rd, 32'h000000C8);
		rdr(0, ST); check("fifo_off_st", rd[7:6], 2'b00);
		wr(0, ufc_pkg::OFF_PIN_SELECT, 32'h00000001);
		// every trigger code, mode 0
		for (int k = 0; k < 4; k++) begin
			wr(0, FC, {24'h000000, 2'(k), 6'h03});
			repeat (lv[k] - 1) i_ser.push(0, 8'h5A);
			idle(); rdr(0, ST); check("below_trig", rd[2], 1'b0);
			check("pin_mode0", multifunction_pin[0], (lv[k] == 1) ? 1'b1 : 1'b0);
			i_ser.push(0, 8'h5A);
			idle(); rdr(0, ST); check("at_trig", rd[2], 1'b1);
			check("pin_held", multifunction_pin[0], 1'b0);
			rdr(0, RX); check("rx_char", rd, 32'h0000005A);
			idle(); rdr(0, ST); check("int_drop", rd[2], 1'b0);
		end
		repeat (4) i_ser.push(0, 8'h33);
		idle(); rdr(0, ST); check("rx_full", rd[12:8], 5'h10);
		repeat (16) rdr(0, RX);
		idle(); check("pin_empty", multifunction_pin[0], 1'b1);
		// mode 1 receive, trigger of four
		wr(0, FC, 32'h0000004B);
		repeat (3) i_ser.push(0, 8'h11);
		idle(); check("pin1_below", multifunction_pin[0], 1'b1);
		i_ser.push(0, 8'h11);
		idle(); check("pin1_trig", multifunction_pin[0], 1'b0);
		repeat (3) rdr(0, RX);
		idle(); check("pin1_hold", multifunction_pin[0], 1'b0);
		rdr(0, RX);
		idle(); check("pin1_empty", multifunction_pin[0], 1'b1);
		i_ser.push(0, 8'h22); i_ser.tmo(0);
		idle(); check("pin1_tmo", multifunction_pin[0], 1'b0);
		// pin must stay high while it is not selected for receive ready
		wr(0, ufc_pkg::OFF_PIN_SELECT, 32'h00000000);
		idle(); check("pin_unsel", multifunction_pin[0], 1'b1);
		wr(0, ufc_pkg::OFF_PIN_SELECT, 32'h00000001);
		idle(); check("pin_resel", multifunction_pin[0], 1'b0);
		wr(0, FC, 32'h0000004B); rdr(0, ST); check("rx_flush", rd[12:8], 5'h00);
		// mode 1 transmit
		repeat (15) wr(0, TX, 32'h00000077);
		idle(); check("tx1_room", transmit_ready_n[0], 1'b0);
		wr(0, TX, 32'h00000077);
		idle(); check("tx1_full", transmit_ready_n[0], 1'b1);
		i_ser.take(0);
		idle(); check("tx1_take", transmit_ready_n[0], 1'b0);
		wr(0, FC, 32'h0000004D); rdr(0, TX); check("tx_flush", rd, 32'h00000000);
		// mode 0 transmit
		wr(0, FC, 32'h00000001);
		idle(); check("tx0_empty", transmit_ready_n[0], 1'b0);
		wr(0, TX, 32'h000000A5);
		idle(); check("tx0_loaded", transmit_ready_n[0], 1'b1);
		check("tx_head", tx_char[7:0], 8'hA5);
		i_ser.take(0);
		idle(); check("tx0_drained", transmit_ready_n[0], 1'b0);
		// second channel and an unmapped place
		wr(1, FC, 32'h00000081); rdr(0, FC); check("ch_a_kept", rd, 32'h00000001);
		rdr(1, FC); check("ch_b_fc", rd, 32'h00000081);
		wr(1, TX, 32'h0000003C);
		idle(); check("txr_b_loaded", transmit_ready_n[1], 1'b1);
		check("tx_b_head", tx_char[15:8], 8'h3C);
		check("txr_a_kept", transmit_ready_n[0], 1'b0);
		i_ser.push(1, 8'h66);
		idle(); check("pin_b_unsel", multifunction_pin[1], 1'b1);
		wr(1, ufc_pkg::OFF_PIN_SELECT, 32'h00000001);
		idle(); check("pin_b_rx", multifunction_pin[1], 1'b0);
		check("pin_a_kept", multifunction_pin[0], 1'b1);
		rdr(1, RX); check("rx_b_char", rd, 32'h00000066);
		idle(); check("pin_b_empty", multifunction_pin[1], 1'b1);
		rdr(0, 8'h1C); check("unmapped", err_seen, 1'b1);
		conclude();
	end
endmodule : tb
